// ==== shared/asu_pkg.sv ====
package asu_pkg;

   // Timing: bit rate = clock / (oversample * baud divider).
   localparam int CLK_HZ = 25_000_000;
   localparam int MIDI_BPS = 31_250;
   localparam int OVERSAMPLE = 16;
   localparam logic [7:0] BAUD_DIV_RST = 8'(CLK_HZ / (OVERSAMPLE * MIDI_BPS));
   localparam logic [3:0] MID_TICK = 4'h7;
   localparam logic [3:0] LAST_TICK = 4'hF;

   // Byte addresses of the register map.
   localparam logic [31:0] CH0_BASE = 32'hFFFFF300;
   localparam logic [31:0] CH1_BASE = 32'hFFFFF310;
   localparam logic [31:0] BAUD_BASE = 32'hFFFFF320;
   localparam logic [31:0] OFS_MODE = 32'h00000000;
   localparam logic [31:0] OFS_TX_HOLD = 32'h00000004;
   localparam logic [31:0] OFS_RX_HOLD = 32'h00000008;
   localparam logic [31:0] OFS_STATUS = 32'h0000000C;
   localparam logic [31:0] BAUD_STRIDE = 32'h00000004;

   // Mode register fields.
   localparam int MODE_TXE = 7;
   localparam int MODE_RXE = 6;
   localparam int MODE_PS_HI = 5;
   localparam int MODE_PS_LO = 4;
   localparam int MODE_CLEN = 3;
   localparam int MODE_SLEN = 2;
   localparam int MODE_EIM = 1;
   // Status register fields.
   localparam int STAT_PE = 2;
   localparam int STAT_FE = 1;
   localparam int STAT_OV = 0;
   // Baud register: bits 7:0 divider, bit 8 selects the external clock pin.
   localparam int BAUD_EXT = 8;

   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [7:0] HOLD_RST = 8'hFF;
   localparam logic [2:0] STAT_RST = 3'h0;
   localparam logic [8:0] BAUD_RST = {1'b0, BAUD_DIV_RST};

   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} asu_rx_e;

   typedef struct packed {
      logic [7:0] mode;
      logic [7:0] tx_hold;
      logic tx_go;
      logic [7:0] rx_hold;
      logic [2:0] status;
      logic rx_full;
      logic [8:0] baud;
      asu_rx_e state;
      logic [3:0] sub;
      logic [3:0] bitn;
      logic [7:0] rx_shifter;
      logic par_rx;
      logic prev_in;
      logic done;
   } asu_ch_s;

   // Parity bit for a character under the given parity field.
   function automatic logic par_bit(input logic [7:0] d, input logic len8,
                                    input logic [1:0] ps);
      logic [7:0] m;
      m = len8 ? d : {1'b0, d[6:0]};
      case (ps)
         2'b10: par_bit = ~^m;
         2'b11: par_bit = ^m;
         default: par_bit = 1'b0;
      endcase
   endfunction

endpackage

// ==== hw/asu_baud_gen.sv ====
`timescale 1ns/10ps
module asu_baud_gen (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Setup
   input wire logic [7:0] divider,
   input wire logic use_ext,
   input wire logic ext_pin,
   // Oversample tick
   output logic tick
);
   typedef struct packed {
      logic [7:0] cnt;
      logic ext_prev;
      logic tick;
   } asu_bg_s;

   asu_bg_s s_reg, s_next;

   always_comb begin
      logic ev;
      ev = 1'b0;
      s_next = s_reg;
      s_next.tick = 1'b0;
      s_next.ext_prev = ext_pin;
      ev = use_ext ? (ext_pin & ~s_reg.ext_prev) : 1'b1;
      if (ev) begin
         // A divider of 0 or 1 ticks on every source event.
         if (divider <= 8'h01 || s_reg.cnt >= divider - 8'h01) begin
            s_next.cnt = 8'h00;
            s_next.tick = 1'b1;
         end else begin
            s_next.cnt = s_reg.cnt + 8'h01;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign tick = s_reg.tick;
endmodule // asu_baud_gen

// ==== hw/asu_tx_ser.sv ====
`timescale 1ns/10ps
module asu_tx_ser (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Control
   input wire logic enable,
   input wire logic tick,
   input wire logic start,
   input wire logic [7:0] data,
   input wire logic len8,
   input wire logic [1:0] ps,
   input wire logic two_stop,
   // Line and state
   output logic line,
   output logic busy
);
   typedef struct packed {
      logic busy;
      logic [3:0] sub;
      logic [3:0] left;
      logic [11:0] frame;
      logic line;
   } asu_tx_s;

   asu_tx_s s_reg, s_next;

   always_comb begin
      logic [11:0] f;
      logic [3:0] n;
      f = '1;
      n = len8 ? 4'h8 : 4'h7;
      s_next = s_reg;
      if (!enable) begin
         s_next.busy = 1'b0;
         s_next.line = 1'b1;
      end else if (start && !s_reg.busy) begin
         f = len8 ? {3'h7, data, 1'b0} : {4'hF, data[6:0], 1'b0};
         if (ps != 2'b00) begin
            f[n + 4'h1] = asu_pkg::par_bit(data, len8, ps);
         end
         s_next.frame = f;
         s_next.left = 4'h1 + n + {3'h0, ps != 2'b00} + (two_stop ? 4'h2 : 4'h1);
         s_next.sub = 4'h0;
         s_next.busy = 1'b1;
         s_next.line = 1'b0;
      end else if (s_reg.busy && tick) begin
         if (s_reg.sub == asu_pkg::LAST_TICK) begin
            s_next.sub = 4'h0;
            s_next.frame = {1'b1, s_reg.frame[11:1]};
            s_next.left = s_reg.left - 4'h1;
            if (s_reg.left == 4'h1) begin
               s_next.busy = 1'b0;
               s_next.line = 1'b1;
            end else begin
               s_next.line = s_reg.frame[1];
            end
         end else begin
            s_next.sub = s_reg.sub + 4'h1;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         s_reg <= '{busy: 1'b0, sub: 4'h0, left: 4'h0, frame: '1, line: 1'b1};
      end else begin
         s_reg <= s_next;
      end
   end

   assign line = s_reg.line;
   assign busy = s_reg.busy;
endmodule // asu_tx_ser

// ==== hw/asu_uart_top.sv ====
`timescale 1ns/10ps
module asu_uart_top (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Avalon-MM slave
   input wire logic [31:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Serial pins
   input wire logic [1:0] serial_in_pin,
   input wire logic [1:0] ext_baud_clk_pin,
   output logic [1:0] serial_out_pin,
   output logic [1:0] tx_pin_serial,
   output logic [1:0] rx_pin_serial,
   // Events
   output logic [1:0] rx_done
);
   typedef struct packed {
      asu_pkg::asu_ch_s [1:0] ch;
      logic ack;
      logic [31:0] rdata;
   } asu_top_s;

   asu_top_s s_reg, s_next;
   logic [1:0] tick;
   logic [1:0] tx_busy;
   logic [1:0] tx_line;
   logic [1:0] rx_cpl;
   logic [1:0] rx_err;

   function automatic logic hit(input logic [31:0] a, input logic [31:0] base,
                                input logic [31:0] ofs);
      hit = (a == base + ofs);
   endfunction

   for (genvar c = 0; c < 2; c++) begin : g_ch
      asu_baud_gen u_baud (
         .ref_clk(ref_clk),
         .rstn(rstn),
         .divider(s_reg.ch[c].baud[7:0]),
         .use_ext(s_reg.ch[c].baud[asu_pkg::BAUD_EXT]),
         .ext_pin(ext_baud_clk_pin[c]),
         .tick(tick[c])
      );
      asu_tx_ser u_tx (
         .ref_clk(ref_clk),
         .rstn(rstn),
         .enable(s_reg.ch[c].mode[asu_pkg::MODE_TXE]),
         .tick(tick[c]),
         .start(s_reg.ch[c].tx_go),
         .data(s_reg.ch[c].tx_hold),
         .len8(s_reg.ch[c].mode[asu_pkg::MODE_CLEN]),
         .ps(s_reg.ch[c].mode[asu_pkg::MODE_PS_HI:asu_pkg::MODE_PS_LO]),
         .two_stop(s_reg.ch[c].mode[asu_pkg::MODE_SLEN]),
         .line(tx_line[c]),
         .busy(tx_busy[c])
      );
   end

   always_comb begin
      logic take;
      logic fetch;
      logic line;
      logic len8;
      logic [1:0] ps;
      logic [3:0] n;
      logic [7:0] d;
      logic pe;
      logic fe;
      logic [31:0] base;
      take = 1'b0;
      fetch = 1'b0;
      line = 1'b1;
      len8 = 1'b0;
      ps = 2'b00;
      n = 4'h0;
      d = 8'h00;
      pe = 1'b0;
      fe = 1'b0;
      base = 32'h0;
      s_next = s_reg;
      rx_cpl = 2'b00;
      rx_err = 2'b00;
      // One wait state: a write is taken on the cycle ack is high. Read data is
      // fetched a cycle earlier, so that it stands while waitrequest is low.
      take = s_reg.ack && (read || write);
      fetch = read && !s_reg.ack;
      s_next.ack = (read || write) && !s_reg.ack;
      if (fetch) begin
         s_next.rdata = 32'h0;
      end
      for (int c = 0; c < 2; c++) begin
         base = (c == 0) ? asu_pkg::CH0_BASE : asu_pkg::CH1_BASE;
         s_next.ch[c].tx_go = 1'b0;
         s_next.ch[c].done = 1'b0;
         // Register access; unmapped addresses read zero and ignore writes.
         if (take && write && byteenable[0]) begin
            if (hit(address, base, asu_pkg::OFS_MODE)) begin
               s_next.ch[c].mode = {writedata[7:1], 1'b0};
            end else if (hit(address, base, asu_pkg::OFS_TX_HOLD)) begin
               s_next.ch[c].tx_hold = writedata[7:0];
               // Back-to-back writes during a send are refused by the serializer.
               s_next.ch[c].tx_go = s_reg.ch[c].mode[asu_pkg::MODE_TXE];
            end else if (hit(address, asu_pkg::BAUD_BASE,
                             (c == 0) ? 32'h0 : asu_pkg::BAUD_STRIDE)) begin
               s_next.ch[c].baud[7:0] = writedata[7:0];
               if (byteenable[1]) begin
                  s_next.ch[c].baud[asu_pkg::BAUD_EXT] = writedata[asu_pkg::BAUD_EXT];
               end
            end
         end
         if (fetch) begin
            if (hit(address, base, asu_pkg::OFS_MODE)) begin
               s_next.rdata[7:0] = s_reg.ch[c].mode;
            end else if (hit(address, base, asu_pkg::OFS_RX_HOLD)) begin
               s_next.rdata[7:0] = s_reg.ch[c].rx_hold;
               s_next.ch[c].rx_full = 1'b0;
            end else if (hit(address, base, asu_pkg::OFS_STATUS)) begin
               s_next.rdata[2:0] = s_reg.ch[c].status;
            end else if (hit(address, asu_pkg::BAUD_BASE,
                             (c == 0) ? 32'h0 : asu_pkg::BAUD_STRIDE)) begin
               s_next.rdata[8:0] = s_reg.ch[c].baud;
            end
         end
         // Receiver.
         line = serial_in_pin[c];
         len8 = s_reg.ch[c].mode[asu_pkg::MODE_CLEN];
         ps = s_reg.ch[c].mode[asu_pkg::MODE_PS_HI:asu_pkg::MODE_PS_LO];
         n = len8 ? 4'h8 : 4'h7;
         d = len8 ? s_reg.ch[c].rx_shifter : {1'b0, s_reg.ch[c].rx_shifter[7:1]};
         s_next.ch[c].prev_in = line;
         if (!s_reg.ch[c].mode[asu_pkg::MODE_RXE]) begin
            s_next.ch[c].state = asu_pkg::RX_IDLE;
         end else begin
            case (s_reg.ch[c].state)
               asu_pkg::RX_IDLE: begin
                  if (s_reg.ch[c].prev_in && !line) begin
                     s_next.ch[c].state = asu_pkg::RX_START;
                     s_next.ch[c].sub = 4'h0;
                  end
               end
               asu_pkg::RX_START: begin
                  if (tick[c]) begin
                     if (s_reg.ch[c].sub == asu_pkg::MID_TICK) begin
                        // A start bit that is high again at mid-bit was a glitch.
                        s_next.ch[c].state = line ? asu_pkg::RX_IDLE : asu_pkg::RX_DATA;
                        s_next.ch[c].sub = 4'h0;
                        s_next.ch[c].bitn = 4'h0;
                     end else begin
                        s_next.ch[c].sub = s_reg.ch[c].sub + 4'h1;
                     end
                  end
               end
               asu_pkg::RX_DATA: begin
                  if (tick[c]) begin
                     s_next.ch[c].sub = s_reg.ch[c].sub + 4'h1;
                     if (s_reg.ch[c].sub == asu_pkg::LAST_TICK) begin
                        s_next.ch[c].rx_shifter = {line, s_reg.ch[c].rx_shifter[7:1]};
                        s_next.ch[c].bitn = s_reg.ch[c].bitn + 4'h1;
                        if (s_reg.ch[c].bitn == n - 4'h1) begin
                           s_next.ch[c].state = (ps != 2'b00) ? asu_pkg::RX_PAR
                                                              : asu_pkg::RX_STOP;
                        end
                     end
                  end
               end
               asu_pkg::RX_PAR: begin
                  if (tick[c]) begin
                     s_next.ch[c].sub = s_reg.ch[c].sub + 4'h1;
                     if (s_reg.ch[c].sub == asu_pkg::LAST_TICK) begin
                        s_next.ch[c].par_rx = line;
                        s_next.ch[c].state = asu_pkg::RX_STOP;
                     end
                  end
               end
               asu_pkg::RX_STOP: begin
                  if (tick[c]) begin
                     s_next.ch[c].sub = s_reg.ch[c].sub + 4'h1;
                     if (s_reg.ch[c].sub == asu_pkg::LAST_TICK) begin
                        // Only the first stop bit is checked.
                        fe = !line;
                        pe = ps[1] && (s_reg.ch[c].par_rx
                                       != asu_pkg::par_bit(d, len8, ps));
                        rx_cpl[c] = 1'b1;
                        rx_err[c] = pe || fe || s_reg.ch[c].rx_full;
                        s_next.ch[c].rx_hold = d;
                        s_next.ch[c].status = {pe, fe, s_reg.ch[c].rx_full};
                        // Completion wins over a same-cycle read of the holding register.
                        s_next.ch[c].rx_full = 1'b1;
                        s_next.ch[c].done = !(rx_err[c]
                                              && s_reg.ch[c].mode[asu_pkg::MODE_EIM]);
                        s_next.ch[c].state = asu_pkg::RX_IDLE;
                     end
                  end
               end
               default: begin
                  s_next.ch[c].state = asu_pkg::RX_IDLE;
               end
            endcase
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         s_reg.ack <= 1'b0;
         s_reg.rdata <= 32'h0;
         for (int c = 0; c < 2; c++) begin
            s_reg.ch[c] <= '{mode: asu_pkg::MODE_RST, tx_hold: asu_pkg::HOLD_RST,
                             tx_go: 1'b0, rx_hold: asu_pkg::HOLD_RST,
                             status: asu_pkg::STAT_RST, rx_full: 1'b0,
                             baud: asu_pkg::BAUD_RST, state: asu_pkg::RX_IDLE,
                             sub: 4'h0, bitn: 4'h0, rx_shifter: 8'h00,
                             par_rx: 1'b0, prev_in: 1'b1, done: 1'b0};
         end
      end else begin
         s_reg <= s_next;
      end
   end

   assign readdata = s_reg.rdata;
   assign waitrequest = (read || write) && !s_reg.ack;
   always_comb begin
      for (int c = 0; c < 2; c++) begin
         tx_pin_serial[c] = s_reg.ch[c].mode[asu_pkg::MODE_TXE];
         rx_pin_serial[c] = s_reg.ch[c].mode[asu_pkg::MODE_RXE];
         serial_out_pin[c] = tx_line[c];
         rx_done[c] = s_reg.ch[c].done;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   a_tx_go_busy: assert property (s_reg.ch[0].tx_go && !tx_busy[0] |=> tx_busy[0])
      else $error("write did not start transmission");
   a_tx_start_bit: assert property (s_reg.ch[0].tx_go && !tx_busy[0] |=> !tx_line[0])
      else $error("start bit not driven low");
   a_rx_seven_msb: assert property (
         rx_cpl[0] && !s_reg.ch[0].mode[asu_pkg::MODE_CLEN] |=> !s_reg.ch[0].rx_hold[7])
      else $error("seven-bit receive left bit 7 set");
   a_mode_bit0: assert property (!s_reg.ch[0].mode[0] && !s_reg.ch[1].mode[0])
      else $error("mode bit 0 not zero");
   a_rx_stopped: assert property (
         !s_reg.ch[0].mode[asu_pkg::MODE_RXE] |=> s_reg.ch[0].state == asu_pkg::RX_IDLE)
      else $error("receiver runs while disabled");
   a_overrun_flag: assert property (
         rx_cpl[0] && s_reg.ch[0].rx_full |=> s_reg.ch[0].status[asu_pkg::STAT_OV])
      else $error("overrun not flagged");
   a_framing_flag: assert property (
         rx_cpl[0] && !serial_in_pin[0] |=> s_reg.ch[0].status[asu_pkg::STAT_FE])
      else $error("framing error not flagged");
   a_irq_masked: assert property (
         rx_cpl[0] && rx_err[0] && s_reg.ch[0].mode[asu_pkg::MODE_EIM] |=> !rx_done[0])
      else $error("completion event not suppressed");
   a_irq_clean: assert property (rx_cpl[0] && !rx_err[0] |=> rx_done[0] ##1 !rx_done[0])
      else $error("clean completion event missing");
   a_bus_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("bus answer late");
   a_bus_idle: assert property (!read && !write |-> !waitrequest)
      else $error("waitrequest raised with no request");
   a_done_single: assert property (rx_done[0] |=> !rx_done[0])
      else $error("completion event longer than one cycle");
   a_tx_go_enabled: assert property (
         s_reg.ch[0].tx_go |-> s_reg.ch[0].mode[asu_pkg::MODE_TXE])
      else $error("send started with transmitter disabled");
   a_tx_off_idle: assert property (
         !s_reg.ch[0].mode[asu_pkg::MODE_TXE] |=> serial_out_pin[0])
      else $error("transmit line not idle while disabled");
   a_tx_off_abort: assert property (
         tx_busy[0] && !s_reg.ch[0].mode[asu_pkg::MODE_TXE] |=> !tx_busy[0])
      else $error("send not aborted when disabled");
   a_no_par_check: assert property (
         rx_cpl[0] && !s_reg.ch[0].mode[asu_pkg::MODE_PS_HI]
         |=> !s_reg.ch[0].status[asu_pkg::STAT_PE])
      else $error("parity error without parity checking");

   // The second channel runs the same loop body; a few checks watch it as well.
   a_ch1_go_busy: assert property (
         s_reg.ch[1].tx_go && !tx_busy[1] |=> tx_busy[1])
      else $error("channel 1 write did not start transmission");
   a_ch1_start_bit: assert property (
         s_reg.ch[1].tx_go && !tx_busy[1] |=> !tx_line[1])
      else $error("channel 1 start bit not driven low");
   a_ch1_tx_idle: assert property (
         !s_reg.ch[1].mode[asu_pkg::MODE_TXE] |=> serial_out_pin[1])
      else $error("channel 1 transmit line not idle while disabled");
   a_ch1_rx_stopped: assert property (
         !s_reg.ch[1].mode[asu_pkg::MODE_RXE] |=> s_reg.ch[1].state == asu_pkg::RX_IDLE)
      else $error("channel 1 receiver runs while disabled");
   a_ch1_seven_msb: assert property (
         rx_cpl[1] && !s_reg.ch[1].mode[asu_pkg::MODE_CLEN] |=> !s_reg.ch[1].rx_hold[7])
      else $error("channel 1 seven-bit receive left bit 7 set");
   a_ch1_overrun: assert property (
         rx_cpl[1] && s_reg.ch[1].rx_full |=> s_reg.ch[1].status[asu_pkg::STAT_OV])
      else $error("channel 1 overrun not flagged");
   a_ch1_framing: assert property (
         rx_cpl[1] && !serial_in_pin[1] |=> s_reg.ch[1].status[asu_pkg::STAT_FE])
      else $error("channel 1 framing error not flagged");
   a_ch1_no_par: assert property (
         rx_cpl[1] && !s_reg.ch[1].mode[asu_pkg::MODE_PS_HI]
         |=> !s_reg.ch[1].status[asu_pkg::STAT_PE])
      else $error("channel 1 parity error without parity checking");
   a_ch1_irq_clean: assert property (
         rx_cpl[1] && !rx_err[1] |=> rx_done[1])
      else $error("channel 1 clean completion event missing");
   a_ch1_irq_masked: assert property (
         rx_cpl[1] && rx_err[1] && s_reg.ch[1].mode[asu_pkg::MODE_EIM] |=> !rx_done[1])
      else $error("channel 1 completion event not suppressed");

   c_rx_char: cover property (rx_cpl[0] && !rx_err[0]);
   c_overrun: cover property (rx_cpl[1] && s_reg.ch[1].rx_full);
   c_tx_ch1: cover property (s_reg.ch[1].tx_go ##1 tx_busy[1]);
   c_parity_err: cover property (rx_cpl[0] ##1 s_reg.ch[0].status[asu_pkg::STAT_PE]);
   c_ch1_rx: cover property (rx_cpl[1] && !rx_err[1]);
endmodule // asu_uart_top

// ==== sim/asu_serial_peer.sv ====
`timescale 1ns/10ps
module asu_serial_peer #(
   parameter int BIT_CYC = 32
) (
   // Clock
   input wire logic ref_clk,
   // Serial lines
   input wire logic from_dev,
   output logic to_dev,
   // Capture of one frame after its start bit
   input wire logic [3:0] cap_bits,
   output logic [11:0] cap_frame
);
   event got;

   initial to_dev = 1'b1;

   // The caller builds data, parity and stop bits in line order, so faults can be sent on purpose.
   task automatic send(input logic [11:0] frame, input int nbits);
      to_dev <= 1'b0;
      repeat (BIT_CYC) @(posedge ref_clk);
      for (int i = 0; i < nbits; i++) begin
         to_dev <= frame[i];
         repeat (BIT_CYC) @(posedge ref_clk);
      end
      to_dev <= 1'b1;
   endtask

   // Sampling mid-bit keeps the capture blind to where inside a bit the edges fall.
   always begin
      @(negedge from_dev);
      repeat (BIT_CYC / 2) @(posedge ref_clk);
      cap_frame = 12'h000;
      for (int i = 0; i < cap_bits; i++) begin
         repeat (BIT_CYC) @(posedge ref_clk);
         cap_frame[i] = from_dev;
      end
      -> got;
   end
endmodule // asu_serial_peer

// ==== sim/asu_uart_top_bench.sv ====
`timescale 1ns/10ps
module asu_uart_top_bench;
   localparam logic [31:0] M0 = asu_pkg::CH0_BASE;
   localparam logic [31:0] M1 = asu_pkg::CH1_BASE;
   localparam logic [31:0] TXH = asu_pkg::OFS_TX_HOLD;
   localparam logic [31:0] RXH = asu_pkg::OFS_RX_HOLD;
   localparam logic [31:0] ST = asu_pkg::OFS_STATUS;
   localparam logic [31:0] BD = asu_pkg::BAUD_BASE;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic [31:0] address = 32'h0;
   logic [31:0] writedata = 32'h0;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [3:0] byteenable = 4'hF;
   logic [1:0] ext_baud_clk_pin = 2'h0;
   logic [1:0] serial_in_pin, serial_out_pin, tx_pin_serial, rx_pin_serial, rx_done;
   logic [31:0] readdata, sink;
   logic waitrequest, peer_line;
   logic [3:0] cap_bits = 4'h9;
   logic [11:0] cap_frame;
   logic [31:0] exp_q[$], got_q[$];
   string name_q[$];
   logic [7:0] d;
   int mismatches = 0, checks = 0, cycles = 0, dones = 0, frames = 0, seed = 32'hF476, n0;
   int dones1 = 0;

   always #20 ref_clk = ~ref_clk;
   always @(posedge ref_clk) ext_baud_clk_pin <= ~ext_baud_clk_pin;
   // Channel 1 hears its own transmitter, which checks the external clock path end to end.
   assign serial_in_pin = {serial_out_pin[1], peer_line};

   asu_uart_top u_asu_uart_top (.ref_clk, .rstn, .address, .read, .write, .writedata,
      .byteenable, .readdata, .waitrequest, .serial_in_pin, .ext_baud_clk_pin,
      .serial_out_pin, .tx_pin_serial, .rx_pin_serial, .rx_done);
   asu_serial_peer #(.BIT_CYC(32)) u_asu_serial_peer (.ref_clk, .from_dev(serial_out_pin[0]),
      .to_dev(peer_line), .cap_bits, .cap_frame);

   always @(u_asu_serial_peer.got) begin
      got_q.push_back({20'h0, cap_frame});
      frames++;
   end

   always @(posedge ref_clk) begin
      cycles++;
      if (rx_done[0] === 1'b1) dones++;
      if (rx_done[1] === 1'b1) dones1++;
      if (cycles == 20000) begin
         mismatches++;
         tally_and_finish();
      end
   end

   always @(negedge ref_clk) begin : watch
      logic [31:0] e, g;
      string n;
      while (got_q.size() > 0 && exp_q.size() > 0) begin
         e = exp_q.pop_front();
         g = got_q.pop_front();
         n = name_q.pop_front();
         checks++;
         if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %0h seen %0h", n, e, g);
         end
      end
   end

   task automatic tally_and_finish();
      mismatches += exp_q.size();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic note(input string n, input logic [31:0] e);
      name_q.push_back(n);
      exp_q.push_back(e);
   endtask

   task automatic see(input string n, input logic [31:0] e, input logic [31:0] g);
      note(n, e);
      got_q.push_back(g);
   endtask

   // Entered just after a rising edge; read data is taken at the edge that sees waitrequest low.
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] dat,
                      input logic [3:0] be, output logic [31:0] q);
      int n;
      n = 0;
      address <= a;
      writedata <= dat;
      byteenable <= be;
      read <= ~wr;
      write <= wr;
      do begin
         @(posedge ref_clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 20);
      if (waitrequest !== 1'b0) mismatches++;
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] dat);
      bus(1'b1, a, dat, 4'hF, sink);
   endtask

   task automatic rd(input string n, input logic [31:0] a, input logic [31:0] e);
      logic [31:0] g;
      note(n, e);
      bus(1'b0, a, 32'h0, 4'hF, g);
      got_q.push_back(g);
   endtask

   task automatic tx_one(input logic [7:0] m, input logic [7:0] dat);
      logic [11:0] f;
      int nb, k;
      nb = m[3] ? 8 : 7;
      f = {4'h0, dat & (m[3] ? 8'hFF : 8'h7F)};
      if (m[5:4] != 2'b00) begin
         f[nb] = (m[5:4] == 2'b01) ? 1'b0 : (^f ^ ~m[4]);
         nb++;
      end
      f[nb] = 1'b1;
      f[nb + 1] = m[2];
      nb += 1 + int'(m[2]);
      wr(M0, {24'h0, m});
      cap_bits <= 4'(nb);
      note("tx frame", {20'h0, f});
      k = frames;
      wr(M0 + TXH, {24'h0, dat});
      for (int i = 0; i < 600 && frames == k; i++) @(posedge ref_clk);
      repeat (40) @(posedge ref_clk);
   endtask

   task automatic rx_one(input logic [7:0] m, input logic [11:0] fr, input int nb,
                         input logic [2:0] es, input int en, input logic rdd,
                         input logic [7:0] ed);
      n0 = dones;
      wr(M0, {24'h0, m});
      u_asu_serial_peer.send(fr, nb);
      repeat (4) @(posedge ref_clk);
      see("rx done count", 32'(en), 32'(dones - n0));
      rd("status", M0 + ST, {29'h0, es});
      if (rdd) rd("rx data", M0 + RXH, {24'h0, ed});
   endtask

   initial begin
      repeat (4) @(posedge ref_clk);
      rstn <= 1'b1;
      @(posedge ref_clk);
      rd("mode0", M0, 32'h0);
      rd("mode1", M1, 32'h0);
      rd("tx hold read", M0 + TXH, 32'h0);
      rd("rx hold0", M0 + RXH, 32'hFF);
      rd("rx hold1", M1 + RXH, 32'hFF);
      rd("status0", M0 + ST, 32'h0);
      rd("baud0", BD, 32'(25_000_000 / (16 * 31_250)));
      rd("unmapped", BD + 32'h10, 32'h0);
      bus(1'b1, M0, 32'hFF, 4'h0, sink);
      rd("mode lane off", M0, 32'h0);
      wr(M0, 32'hFF);
      rd("mode bit0", M0, 32'hFE);
      wr(M0 + RXH, 32'h00);
      wr(M0 + ST, 32'h07);
      rd("rx hold ro", M0 + RXH, 32'hFF);
      rd("status ro", M0 + ST, 32'h0);
      $display("test registers done");
      for (int i = 0; i < 4; i++) begin
         wr(M0, {24'h0, 2'(i), 6'h0});
         @(negedge ref_clk);
         see("pin function", 32'(i), {30'h0, tx_pin_serial[0], rx_pin_serial[0]});
         @(posedge ref_clk);
      end
      wr(M0, 32'h40);
      n0 = frames;
      wr(M0 + TXH, 32'hA5);
      repeat (400) @(posedge ref_clk);
      see("frames with tx off", 32'(n0), 32'(frames));
      $display("test pin function done");
      wr(BD, 32'h02);
      for (int i = 0; i < 8; i++) begin
         d = 8'($random(seed));
         tx_one({2'b11, 2'(i), i[2], i[0], 2'b00}, d);
      end
      $display("test transmit framing done");
      d = 8'($random(seed));
      rx_one(8'hC8, {3'h0, 1'b1, d}, 9, 3'h0, 1, 1'b1, d);
      rx_one(8'hC0, {4'h0, 1'b1, d[6:0]}, 8, 3'h0, 1, 1'b1, {1'b0, d[6:0]});
      rx_one(8'hF8, {2'h0, 1'b1, ~^d, d}, 10, 3'h4, 1, 1'b1, d);
      rx_one(8'hE8, {2'h0, 1'b1, ~^d, d}, 10, 3'h0, 1, 1'b1, d);
      rx_one(8'hD8, {2'h0, 2'b11, d}, 10, 3'h0, 1, 1'b1, d);
      rx_one(8'hCA, {3'h0, 1'b1, d}, 9, 3'h0, 1, 1'b0, d);
      rx_one(8'hCA, {3'h0, 1'b1, d}, 9, 3'h1, 0, 1'b0, d);
      rx_one(8'hCA, {3'h0, 1'b1, d}, 9, 3'h1, 0, 1'b1, d);
      rx_one(8'hCA, {3'h0, 1'b0, d}, 9, 3'h2, 0, 1'b0, d);
      $display("test receive done");
      wr(BD + asu_pkg::BAUD_STRIDE, 32'h101);
      wr(M1, 32'hC8);
      wr(M1 + TXH, {24'h0, d});
      repeat (500) @(posedge ref_clk);
      rd("ch1 loopback", M1 + RXH, {24'h0, d});
      see("ch1 done count", 32'h1, 32'(dones1));
      $display("test external clock done");
      repeat (2) @(posedge ref_clk);
      tally_and_finish();
   end
endmodule // asu_uart_top_bench
